// file: inc/secure_ctrl_pkg.sv
// Constants, field layout and carrier types of the secure top-level control block
// Overview of operation
// - 32-bit control register exists with two security states; secure accesses only.
// - Compressed-index owner bit: 0 non-secure only, 1 secure only; resets 0.
// - Config-fault override 1 moves non-secure faults bound for secure status to non-secure.
// - Override ignores common/non-secure targets; resets 0; RAZ/WI without config faults.
// - Secure performance enable 0 blocks counting of secure events; resets 0.
// - Fetch guard 1 faults secure-domain non-secure instruction fetches; resets 0.
// - Fetch fault logs to bank status inside a bank, else secure global status.
// - External-fault override 1 moves non-secure external aborts to secure status; resets 0.
// - Global-space restriction 1 admits only secure configuration accesses; resets 0.
// - Interrupt-count cap resets to implemented count; unneeded upper bits RAZ/WI.
// - Non-secure group count reported in identification equals the group cap.
// - Group cap resets to implemented groups, or 128 with extended matching.
// - Non-secure access to unimplemented groups below the group cap faults or is ignored, by choice.
// - Non-secure bank count reported equals bank cap; cap resets to implemented banks.
// - Banks below the cap hand their attribute and syndrome registers to non-secure.
// - Any bank cap change leaves wide address format of reallocated banks unknown.
// - Stalled transactions may be retried after a bank cap change.
package secure_ctrl_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] ENABLE_OFFSET = 8'h08;
	localparam logic [7:0] CLEAR_OFFSET = 8'h0C;
	// ==========================================================
	// Control field positions
	localparam int COMPIDX_BIT = 29;
	localparam int CFG_OVR_BIT = 28;
	localparam int PERF_BIT = 27;
	localparam int FETCH_BIT = 26;
	localparam int EXT_OVR_BIT = 25;
	localparam int GAS_BIT = 24;
	localparam int IRQ_LSB = 16;
	localparam int GRP_LSB = 8;
	localparam int BANK_LSB = 0;
	localparam int CAP_W = 8;
	localparam logic [CAP_W-1:0] EXT_MATCH_GROUPS = 8'h80;
	// ==========================================================
	// Event bits of status, enable and clear
	localparam int EV_W = 6;
	localparam int EV_CFG_SEC = 0;
	localparam int EV_CFG_NS = 1;
	localparam int EV_EXT = 2;
	localparam int EV_FETCH = 3;
	localparam int EV_REG_NS = 4;
	localparam int EV_GROUP = 5;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
		logic secure;
	} reg_req_type;
	typedef struct packed {
		logic sec_global;
		logic ns_global;
		logic bank;
	} fault_log_type;
	typedef struct packed {
		logic compidx_owner;
		logic cfg_ovr;
		logic perf_en;
		logic fetch_guard;
		logic ext_ovr;
		logic gas;
		logic [CAP_W-1:0] irq_cap;
		logic [CAP_W-1:0] grp_cap;
		logic [CAP_W-1:0] bank_cap;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] enable;
		logic [31:0] rdata;
		logic irq;
		fault_log_type log;
		logic fetch_fault;
		logic perf_count;
		logic gas_deny;
		logic grp_fault;
		logic grp_ignore;
		logic compidx_grant;
		logic bank_ns;
		logic realloc;
	} state_type;
endpackage : secure_ctrl_pkg

// file: src/cap_field_keep.sv
// Keeps only the implemented low bits of a count cap field
`timescale 1ns/100ps
module cap_field_keep
	import secure_ctrl_pkg::*;
#(
	parameter int BITS = CAP_W
)
(
	input wire logic [CAP_W-1:0] value,
	output logic [CAP_W-1:0] kept
);
	localparam logic [CAP_W:0] ONE = 9'h001;
	localparam logic [CAP_W:0] FULL = (ONE << BITS) - ONE;

	assign kept = value & FULL[CAP_W-1:0];
endmodule : cap_field_keep

// file: src/secure_top_control.sv
// Secure top-level control register with fault routing, access gating and count caps
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
module secure_top_control
	import secure_ctrl_pkg::*;
#(
	parameter logic [CAP_W-1:0] IMPL_IRQS = 8'h10,
	parameter logic [CAP_W-1:0] IMPL_GROUPS = 8'h20,
	parameter logic [CAP_W-1:0] IMPL_BANKS = 8'h10,
	parameter int IRQ_BITS = 5,
	parameter int GRP_BITS = 8,
	parameter int BANK_BITS = 5,
	parameter bit EXT_MATCH = 1'b0,
	parameter bit CFG_FAULT_GEN = 1'b1,
	parameter bit GROUP_FAULT_ON_UNIMPL = 1'b1
)
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire reg_req_type REG_REQ,
	output logic [31:0] REG_RDATA,
	output logic IRQ,
	input wire logic CFG_FAULT,
	input wire logic CFG_FAULT_NS,
	input wire logic CFG_FAULT_SECURE_REG,
	input wire logic EXT_ABORT,
	input wire logic EXT_ABORT_SECURE,
	input wire logic FETCH_VALID,
	input wire logic FETCH_SECURE_DOMAIN,
	input wire logic FETCH_NS_INSTR,
	input wire logic FETCH_IN_BANK,
	output fault_log_type FAULT_LOG,
	output logic FETCH_PERM_FAULT,
	input wire logic PERF_EVENT,
	input wire logic PERF_EVENT_SECURE,
	output logic PERF_COUNT,
	input wire logic GLOBAL_ACC,
	input wire logic GLOBAL_ACC_NS,
	output logic GLOBAL_ACC_DENY,
	input wire logic GROUP_ACC,
	input wire logic GROUP_ACC_NS,
	input wire logic [CAP_W-1:0] GROUP_ACC_INDEX,
	output logic GROUP_ACC_FAULT,
	output logic GROUP_ACC_IGNORE,
	input wire logic COMPIDX_ACC,
	input wire logic COMPIDX_ACC_NS,
	output logic COMPIDX_GRANT,
	input wire logic [CAP_W-1:0] BANK_QUERY,
	output logic BANK_QUERY_NS,
	output logic COMPIDX_OWNER_SECURE,
	output logic [CAP_W-1:0] NS_IRQ_COUNT,
	output logic [CAP_W-1:0] NS_GROUP_COUNT,
	output logic [CAP_W-1:0] NS_BANK_COUNT,
	output logic BANK_REALLOC
);
	// ==========================================================
	// State and field masking
	localparam logic [CAP_W-1:0] GRP_RESET = EXT_MATCH ? EXT_MATCH_GROUPS : IMPL_GROUPS;
	state_type s_q;
	state_type s_d;
	logic [CAP_W-1:0] irq_keep;
	logic [CAP_W-1:0] grp_keep;
	logic [CAP_W-1:0] bank_keep;
	logic [CAP_W-1:0] irq_rst;
	logic [CAP_W-1:0] grp_rst;
	logic [CAP_W-1:0] bank_rst;
	logic sec_wr;
	logic sec_rd;
	logic [EV_W-1:0] ev;
	logic [31:0] ctrl_word;

	cap_field_keep #(.BITS(IRQ_BITS)) irq_w (.value(REG_REQ.wdata[IRQ_LSB+:CAP_W]), .kept(irq_keep));
	cap_field_keep #(.BITS(GRP_BITS)) grp_w (.value(REG_REQ.wdata[GRP_LSB+:CAP_W]), .kept(grp_keep));
	cap_field_keep #(.BITS(BANK_BITS)) bank_w (.value(REG_REQ.wdata[BANK_LSB+:CAP_W]), .kept(bank_keep));
	cap_field_keep #(.BITS(IRQ_BITS)) irq_r (.value(IMPL_IRQS), .kept(irq_rst));
	cap_field_keep #(.BITS(GRP_BITS)) grp_r (.value(GRP_RESET), .kept(grp_rst));
	cap_field_keep #(.BITS(BANK_BITS)) bank_r (.value(IMPL_BANKS), .kept(bank_rst));

	// ==========================================================
	// Next state
	always_comb
	begin
		s_d = s_q;
		sec_wr = REG_REQ.wr && REG_REQ.secure;
		sec_rd = REG_REQ.rd && REG_REQ.secure;
		ev = '0;
		ctrl_word = '0;
		ctrl_word[COMPIDX_BIT] = s_q.compidx_owner;
		ctrl_word[CFG_OVR_BIT] = s_q.cfg_ovr;
		ctrl_word[PERF_BIT] = s_q.perf_en;
		ctrl_word[FETCH_BIT] = s_q.fetch_guard;
		ctrl_word[EXT_OVR_BIT] = s_q.ext_ovr;
		ctrl_word[GAS_BIT] = s_q.gas;
		ctrl_word[IRQ_LSB+:CAP_W] = s_q.irq_cap;
		ctrl_word[GRP_LSB+:CAP_W] = s_q.grp_cap;
		ctrl_word[BANK_LSB+:CAP_W] = s_q.bank_cap;
		s_d.realloc = 1'b0;
		// Register writes
		if (sec_wr && REG_REQ.addr == CTRL_OFFSET)
		begin
			s_d.compidx_owner = REG_REQ.wdata[COMPIDX_BIT];
			s_d.cfg_ovr = CFG_FAULT_GEN & REG_REQ.wdata[CFG_OVR_BIT];
			s_d.perf_en = REG_REQ.wdata[PERF_BIT];
			s_d.fetch_guard = REG_REQ.wdata[FETCH_BIT];
			s_d.ext_ovr = REG_REQ.wdata[EXT_OVR_BIT];
			s_d.gas = REG_REQ.wdata[GAS_BIT];
			s_d.irq_cap = irq_keep;
			s_d.grp_cap = grp_keep;
			s_d.bank_cap = bank_keep;
			s_d.realloc = bank_keep != s_q.bank_cap;
		end
		if (sec_wr && REG_REQ.addr == ENABLE_OFFSET)
		begin
			s_d.enable = REG_REQ.wdata[EV_W-1:0];
		end
		// Fault routing
		s_d.log = '0;
		if (CFG_FAULT)
		begin
			if (CFG_FAULT_SECURE_REG && !(CFG_FAULT_NS && s_q.cfg_ovr))
			begin
				s_d.log.sec_global = 1'b1;
				ev[EV_CFG_SEC] = 1'b1;
			end
			else
			begin
				s_d.log.ns_global = 1'b1;
				ev[EV_CFG_NS] = 1'b1;
			end
		end
		if (EXT_ABORT)
		begin
			ev[EV_EXT] = 1'b1;
			if (EXT_ABORT_SECURE || s_q.ext_ovr)
				s_d.log.sec_global = 1'b1;
			else
				s_d.log.ns_global = 1'b1;
		end
		s_d.fetch_fault = FETCH_VALID && FETCH_SECURE_DOMAIN && FETCH_NS_INSTR && s_q.fetch_guard;
		if (s_d.fetch_fault)
		begin
			ev[EV_FETCH] = 1'b1;
			if (FETCH_IN_BANK)
				s_d.log.bank = 1'b1;
			else
				s_d.log.sec_global = 1'b1;
		end
		ev[EV_REG_NS] = (REG_REQ.wr || REG_REQ.rd) && !REG_REQ.secure;
		// Gating of other accesses
		s_d.perf_count = PERF_EVENT && (!PERF_EVENT_SECURE || s_q.perf_en);
		s_d.gas_deny = GLOBAL_ACC && GLOBAL_ACC_NS && s_q.gas;
		s_d.grp_fault = 1'b0;
		s_d.grp_ignore = 1'b0;
		if (GROUP_ACC && GROUP_ACC_NS && GROUP_ACC_INDEX >= IMPL_GROUPS
			&& GROUP_ACC_INDEX < s_q.grp_cap)
		begin
			s_d.grp_fault = GROUP_FAULT_ON_UNIMPL;
			s_d.grp_ignore = !GROUP_FAULT_ON_UNIMPL;
		end
		ev[EV_GROUP] = s_d.grp_fault;
		s_d.compidx_grant = COMPIDX_ACC && (COMPIDX_ACC_NS != s_q.compidx_owner);
		s_d.bank_ns = BANK_QUERY < s_q.bank_cap;
		// Status, set wins over clear
		if (sec_wr && REG_REQ.addr == CLEAR_OFFSET)
			s_d.status = s_q.status & ~REG_REQ.wdata[EV_W-1:0];
		s_d.status = s_d.status | ev;
		s_d.irq = |(s_d.status & s_d.enable);
		// Read data, unmapped and non-secure reads give zero
		s_d.rdata = '0;
		if (sec_rd)
		begin
			case (REG_REQ.addr)
				CTRL_OFFSET: s_d.rdata = ctrl_word;
				STATUS_OFFSET: s_d.rdata[EV_W-1:0] = s_q.status;
				ENABLE_OFFSET: s_d.rdata[EV_W-1:0] = s_q.enable;
				default: s_d.rdata = '0;
			endcase
		end
		// Reset values
		if (!RESET_N)
		begin
			s_d = '0;
			s_d.irq_cap = irq_rst;
			s_d.grp_cap = grp_rst;
			s_d.bank_cap = bank_rst;
		end
	end

	always_ff @(posedge CLK)
	begin
		s_q <= s_d;
	end

	// ==========================================================
	// Outputs
	assign REG_RDATA = s_q.rdata;
	assign IRQ = s_q.irq;
	assign FAULT_LOG = s_q.log;
	assign FETCH_PERM_FAULT = s_q.fetch_fault;
	assign PERF_COUNT = s_q.perf_count;
	assign GLOBAL_ACC_DENY = s_q.gas_deny;
	assign GROUP_ACC_FAULT = s_q.grp_fault;
	assign GROUP_ACC_IGNORE = s_q.grp_ignore;
	assign COMPIDX_GRANT = s_q.compidx_grant;
	assign BANK_QUERY_NS = s_q.bank_ns;
	assign COMPIDX_OWNER_SECURE = s_q.compidx_owner;
	assign NS_IRQ_COUNT = s_q.irq_cap;
	assign NS_GROUP_COUNT = s_q.grp_cap;
	assign NS_BANK_COUNT = s_q.bank_cap;
	assign BANK_REALLOC = s_q.realloc;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	nonsec_write_a: assert property (
		(REG_REQ.wr && !REG_REQ.secure) |=> $stable(ctrl_word))
		else $error("Non-secure write altered the control register");

	nonsec_read_a: assert property (
		(REG_REQ.rd && !REG_REQ.secure) |=> REG_RDATA == 32'h0000_0000)
		else $error("Non-secure read returned data");

	cap_reset_a: assert property (
		$rose(RESET_N) |-> NS_BANK_COUNT == bank_rst && NS_GROUP_COUNT == grp_rst && !COMPIDX_OWNER_SECURE)
		else $error("Caps or owner bit wrong after reset");

	cfg_route_a: assert property (
		(CFG_FAULT && CFG_FAULT_NS && CFG_FAULT_SECURE_REG && s_q.cfg_ovr) |=> FAULT_LOG.ns_global)
		else $error("Overridden configuration fault not sent to non-secure status");

	ext_route_a: assert property (
		(EXT_ABORT && !EXT_ABORT_SECURE && s_q.ext_ovr) |=> FAULT_LOG.sec_global)
		else $error("Overridden external abort not sent to secure status");

	fetch_bank_a: assert property (
		(FETCH_VALID && FETCH_SECURE_DOMAIN && FETCH_NS_INSTR && s_q.fetch_guard && FETCH_IN_BANK)
		|=> FETCH_PERM_FAULT && FAULT_LOG.bank)
		else $error("Fetch fault not logged in bank status");

	perf_gate_a: assert property (
		(PERF_EVENT && PERF_EVENT_SECURE && !s_q.perf_en) |=> !PERF_COUNT)
		else $error("Secure event counted while disabled");

	global_deny_a: assert property (
		(GLOBAL_ACC && GLOBAL_ACC_NS && s_q.gas) |=> GLOBAL_ACC_DENY)
		else $error("Non-secure global access not denied");

	bank_realloc_a: assert property (
		(REG_REQ.wr && REG_REQ.secure && REG_REQ.addr == CTRL_OFFSET && bank_keep != NS_BANK_COUNT)
		##1 !(REG_REQ.wr && REG_REQ.secure && REG_REQ.addr == CTRL_OFFSET)
		|-> BANK_REALLOC ##1 !BANK_REALLOC)
		else $error("Bank cap change gave no single reallocation pulse");

	irq_level_a: assert property (
		(|(ev & s_d.enable)) |=> IRQ)
		else $error("Enabled event did not raise the interrupt");

	nonsec_status_a: assert property (
		((REG_REQ.wr || REG_REQ.rd) && !REG_REQ.secure) |=> s_q.status[EV_REG_NS])
		else $error("Non-secure access not flagged in status");
endmodule : secure_top_control

// file: verif/secure_top_control_bench.sv
// Self-checking bench of the secure top-level control register block
`timescale 1ns/100ps
module secure_top_control_bench
	import secure_ctrl_pkg::*;
;
	// ==========================================================
	// Stimulus and wiring
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	reg_req_type req = '0;
	logic [16:0] ev = '0;
	logic [CAP_W-1:0] gidx = 8'h20;
	logic [CAP_W-1:0] bq = 8'h0F;
	logic [31:0] REG_RDATA;
	logic IRQ, FETCH_PERM_FAULT, PERF_COUNT, GLOBAL_ACC_DENY, GROUP_ACC_FAULT, GROUP_ACC_IGNORE, COMPIDX_GRANT;
	logic BANK_QUERY_NS, COMPIDX_OWNER_SECURE, BANK_REALLOC;
	logic [CAP_W-1:0] NS_IRQ_COUNT, NS_GROUP_COUNT, NS_BANK_COUNT;
	fault_log_type FAULT_LOG;
	int n_fail = 0;
	int checks_done = 0;
	always #2.5 CLK = ~CLK;
	secure_top_control dut
	(
		.CLK(CLK), .RESET_N(RESET_N), .REG_REQ(req), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
		.CFG_FAULT(ev[16]), .CFG_FAULT_NS(ev[15]), .CFG_FAULT_SECURE_REG(ev[14]),
		.EXT_ABORT(ev[13]), .EXT_ABORT_SECURE(ev[12]), .FETCH_VALID(ev[11]),
		.FETCH_SECURE_DOMAIN(ev[10]), .FETCH_NS_INSTR(ev[9]), .FETCH_IN_BANK(ev[8]),
		.FAULT_LOG(FAULT_LOG), .FETCH_PERM_FAULT(FETCH_PERM_FAULT),
		.PERF_EVENT(ev[7]), .PERF_EVENT_SECURE(ev[6]), .PERF_COUNT(PERF_COUNT),
		.GLOBAL_ACC(ev[5]), .GLOBAL_ACC_NS(ev[4]), .GLOBAL_ACC_DENY(GLOBAL_ACC_DENY),
		.GROUP_ACC(ev[3]), .GROUP_ACC_NS(ev[2]), .GROUP_ACC_INDEX(gidx),
		.GROUP_ACC_FAULT(GROUP_ACC_FAULT), .GROUP_ACC_IGNORE(GROUP_ACC_IGNORE),
		.COMPIDX_ACC(ev[1]), .COMPIDX_ACC_NS(ev[0]), .COMPIDX_GRANT(COMPIDX_GRANT),
		.BANK_QUERY(bq), .BANK_QUERY_NS(BANK_QUERY_NS), .COMPIDX_OWNER_SECURE(COMPIDX_OWNER_SECURE),
		.NS_IRQ_COUNT(NS_IRQ_COUNT), .NS_GROUP_COUNT(NS_GROUP_COUNT), .NS_BANK_COUNT(NS_BANK_COUNT),
		.BANK_REALLOC(BANK_REALLOC)
	);
	// ==========================================================
	// Shared tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic s);
		@(posedge CLK);
		req <= reg_req_type'{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, secure: s};
		@(posedge CLK);
		req <= '0;
	endtask : wr
	task rd(input logic [7:0] a, input logic s, input logic [31:0] exp);
		@(posedge CLK);
		req <= reg_req_type'{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, secure: s};
		@(posedge CLK);
		req <= '0;
		#1;
		chk(REG_RDATA, exp);
	endtask : rd
	task pulse(input logic [16:0] e, input logic [8:0] exp);
		@(posedge CLK);
		ev <= e;
		@(posedge CLK);
		ev <= '0;
		#1;
		chk({FAULT_LOG, FETCH_PERM_FAULT, PERF_COUNT, GLOBAL_ACC_DENY, GROUP_ACC_FAULT, GROUP_ACC_IGNORE, COMPIDX_GRANT}, exp);
	endtask : pulse
	task end_of_test;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// ==========================================================
	// Scenarios
	task reset_state;
		chk({COMPIDX_OWNER_SECURE, NS_IRQ_COUNT, NS_GROUP_COUNT, NS_BANK_COUNT}, 32'h00102010);
		rd(CTRL_OFFSET, 1'b1, 32'h00102010);
		pulse(17'h1C000, 9'h100);
		pulse(17'h02000, 9'h080);
		pulse(17'h00E00, 9'h000);
		pulse(17'h000C0, 9'h000);
		pulse(17'h00080, 9'h010);
		pulse(17'h00030, 9'h000);
		pulse(17'h00003, 9'h001);
		pulse(17'h00002, 9'h000);
		pulse(17'h0000C, 9'h000);
		chk(BANK_QUERY_NS, 1'b1);
	endtask : reset_state
	task program_ctrl;
		wr(CTRL_OFFSET, 32'h3F0F2808, 1'b1);
		#1;
		chk(BANK_REALLOC, 1'b1);
		rd(CTRL_OFFSET, 1'b1, 32'h3F0F2808);
		chk({COMPIDX_OWNER_SECURE, NS_IRQ_COUNT, NS_GROUP_COUNT, NS_BANK_COUNT}, 32'h010F2808);
		wr(CTRL_OFFSET, 32'h3F0F2808, 1'b1);
		#1;
		chk(BANK_REALLOC, 1'b0);
		wr(CTRL_OFFSET, 32'h00000000, 1'b0);
		rd(CTRL_OFFSET, 1'b1, 32'h3F0F2808);
		rd(CTRL_OFFSET, 1'b0, 32'h00000000);
		rd(8'h10, 1'b1, 32'h00000000);
	endtask : program_ctrl
	task routed_events;
		pulse(17'h1C000, 9'h080);
		pulse(17'h18000, 9'h080);
		pulse(17'h14000, 9'h100);
		pulse(17'h02000, 9'h100);
		pulse(17'h00E00, 9'h120);
		pulse(17'h00F00, 9'h060);
		pulse(17'h000C0, 9'h010);
		pulse(17'h00030, 9'h008);
		pulse(17'h00020, 9'h000);
		pulse(17'h00003, 9'h000);
		pulse(17'h00002, 9'h001);
		pulse(17'h0000C, 9'h004);
		@(posedge CLK);
		gidx <= 8'h1F;
		pulse(17'h0000C, 9'h000);
		@(posedge CLK);
		bq <= 8'h07;
		@(posedge CLK);
		bq <= 8'h08;
		#1;
		chk(BANK_QUERY_NS, 1'b1);
		@(posedge CLK);
		#1;
		chk(BANK_QUERY_NS, 1'b0);
	endtask : routed_events
	task interrupt_flow;
		wr(CLEAR_OFFSET, 32'h0000003F, 1'b1);
		wr(ENABLE_OFFSET, 32'h00000010, 1'b1);
		rd(ENABLE_OFFSET, 1'b1, 32'h00000010);
		rd(STATUS_OFFSET, 1'b1, 32'h00000000);
		chk(IRQ, 1'b0);
		rd(CTRL_OFFSET, 1'b0, 32'h00000000);
		rd(STATUS_OFFSET, 1'b1, 32'h00000010);
		chk(IRQ, 1'b1);
		wr(ENABLE_OFFSET, 32'h00000000, 1'b1);
		repeat (2) @(posedge CLK);
		#1;
		chk(IRQ, 1'b0);
		wr(ENABLE_OFFSET, 32'h00000010, 1'b1);
		wr(CLEAR_OFFSET, 32'h00000010, 1'b1);
		repeat (2) @(posedge CLK);
		#1;
		chk(IRQ, 1'b0);
		rd(STATUS_OFFSET, 1'b1, 32'h00000000);
	endtask : interrupt_flow
	task reset_again;
		@(posedge CLK);
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		#1;
		chk({COMPIDX_OWNER_SECURE, NS_IRQ_COUNT, NS_GROUP_COUNT, NS_BANK_COUNT}, 32'h00102010);
		rd(CTRL_OFFSET, 1'b1, 32'h00102010);
		rd(ENABLE_OFFSET, 1'b1, 32'h00000000);
	endtask : reset_again
	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (16) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		#1;
		reset_state();
		program_ctrl();
		routed_events();
		interrupt_flow();
		reset_again();
		end_of_test();
	end
	initial
	begin
		#20000;
		n_fail++;
		end_of_test();
	end
endmodule : secure_top_control_bench
